// [core/uip_map.svh]
// Offsets, field positions, reset values and timing counts of the interrupt identification block.
// Included by its bare name from the package and the identification module.
`ifndef UIP_MAP_SVH
`define UIP_MAP_SVH

// Register byte offsets on the APB window
`define UIP_OFF_IIR 12'h000
`define UIP_OFF_FCR 12'h004
`define UIP_OFF_LCR 12'h008
`define UIP_OFF_LSR 12'h00C
`define UIP_OFF_ABCR 12'h010
`define UIP_OFF_ISTAT 12'h014
`define UIP_OFF_IEN 12'h018
`define UIP_OFF_ICLR 12'h01C

// Identification register fields
`define UIP_IIR_PEND_BIT 0
`define UIP_IIR_CODE_LSB 1
`define UIP_IIR_FIFO_LSB 6
`define UIP_IIR_ABEND_BIT 8
`define UIP_IIR_ABTO_BIT 9

// Source codes
`define UIP_CODE_NONE 3'h0
`define UIP_CODE_LINE 3'h3
`define UIP_CODE_FILL 3'h2
`define UIP_CODE_IDLE 3'h6
`define UIP_CODE_TRANSMIT_EMPTY_IRQ 3'h1

// FIFO control and line control fields
`define UIP_FCR_EN_BIT 0
`define UIP_FCR_TRIG_LSB 6
`define UIP_LCR_WLS_LSB 0
`define UIP_LCR_STOP_BIT 2
`define UIP_LCR_PAR_BIT 3

// Line condition fields
`define UIP_LSR_RDR_BIT 0
`define UIP_LSR_ERR_LSB 1
`define UIP_LSR_TRANSMIT_EMPTY_IRQ_BIT 5

// Auto-baud clear bits
`define UIP_ABCR_END_BIT 8
`define UIP_ABCR_TO_BIT 9

// Interrupt status layout
`define UIP_ST_LINE 0
`define UIP_ST_FILL 1
`define UIP_ST_IDLE 2
`define UIP_ST_TRANSMIT_EMPTY_IRQ 3
`define UIP_ST_ABEND 4
`define UIP_ST_ABTO 5
`define UIP_ST_W 6

// Reset values
`define UIP_RST_IIR_PEND 1'b1
`define UIP_RST_CODE 3'h0
`define UIP_RST_TRIG 2'h0
`define UIP_RST_WLS 2'h0
`define UIP_RST_IEN 6'h00

// Trigger thresholds in characters
`define UIP_TRIG_L0 5'h01
`define UIP_TRIG_L1 5'h04
`define UIP_TRIG_L2 5'h08
`define UIP_TRIG_L3 5'h0E

// Timing counts in receive clock periods
`define UIP_RCLK_PER_BIT 8'h10
`define UIP_IDLE_MUL 10'h007
`define UIP_IDLE_SUB 10'h002
`define UIP_IDLE_SCALE 10'h008
`define UIP_IDLE_ADD 10'h001
`define UIP_WORD_MIN 10'h005

`endif

// [core/uip_pkg.sv]
// Types shared by the interrupt identification block and its idle timer.
// Assumes uip_map.svh is on the include path.
`include "uip_map.svh"

package uip_pkg;

  typedef logic [2:0] uip_code_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic fcrEn;
    logic [1:0] fcrTrig;
    logic [1:0] lcrWls;
    logic lcrStop;
    logic lcrParity;
    logic [3:0] lsrErr;
    logic lineIrq;
    logic fillIrq;
    logic idleIrq;
    logic threIrq;
    logic threHeld2;
    logic txEmptyPrev;
    logic [7:0] threDelay;
    logic threDelayRun;
    logic abEnd;
    logic abTimeout;
    uip_code_t iirCode;
    logic iirPendN;
    logic [`UIP_ST_W-1:0] status;
    logic [`UIP_ST_W-1:0] ien;
    logic irq;
  } uip_state_t;

  typedef struct packed {
    logic [9:0] count;
    logic expired;
  } uip_tmr_state_t;

endpackage

// [core/uip_tmr_if.sv]
// Link between the identification logic and its receive idle timer.
// Both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface uip_tmr_if;
  logic tick;
  logic activity;
  logic armed;
  logic [9:0] window;
  logic expired;

  modport ctrl (output tick, output activity, output armed, output window, input expired);
  modport timer (input tick, input activity, input armed, input window, output expired);
endinterface

`default_nettype wire

// [core/uip_idle_timer.sv]
// Receive idle timer: counts receive clock ticks while the FIFO holds data.
// Assumes window is stable while armed, except when FIFO fill changes.
`timescale 1ns/1ps
`default_nettype none

module uip_idle_timer (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  uip_tmr_if.timer tmr
);
  import uip_pkg::*;

  uip_tmr_state_t state_reg;
  uip_tmr_state_t state_next;

  assign tmr.expired = state_reg.expired;

  always_comb begin
    state_next = state_reg;
    if (!tmr.armed || tmr.activity) begin
      // Any write or read restarts the idle window
      state_next.count = 10'h000;
      state_next.expired = 1'b0;
    end else if (tmr.tick && !state_reg.expired) begin
      state_next.count = state_reg.count + 10'h001;
      if (state_next.count >= tmr.window) begin
        state_next.expired = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_reg <= '0;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

endmodule

`default_nettype wire

// [core/uip_ident.sv]
// Interrupt identification and prioritisation for an asynchronous serial port, APB slave.
// Assumes FIFO counts, strobes and the receive clock tick are synchronous to clk_sys.
//
// Notes on behaviour
// - With nothing pending the identification nibble reads 0001.
// - Pending flag low when any non auto-baud source is active; field names it.
// - Line error source is highest, code 011, set by overrun, parity, framing, break.
// - Error cause shows in line condition bits 4:1; reading that register clears.
// - Fill (010) and idle timeout (110) form second level, fill shown first, above transmit empty.
// - Fill source follows FIFO level against the selected trigger threshold.
// - Idle timeout when FIFO non-empty and no activity for the window.
// - Any receive FIFO write or read clears the idle timeout.
// - Window is ((len*7)-2)*8 + (trigger-held)*8 + 1 receive clock periods.
// - Transmit empty source, code 001, third level, raised when FIFO empties.
// - Empty without two held characters waits one character less stop bit.
// - Empty after holding two or more characters raises the source at once.
// - Holding register write, or identification read showing 001, clears it.
// - Reserved nibbles 0000, 0011, 0111, 10xx, 1110, 1111 never appear.
// - Identification frozen during its read; new sources show on next read.
// - Auto-baud end and timeout in bits 9:8, cleared only by clear bits.
// - Trigger field 0..3 selects 1, 4, 8 and 14 characters.
`include "uip_map.svh"
`timescale 1ns/1ps
`default_nettype none

module uip_ident (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [4:0] rxFifoCount,
  input wire logic rxFifoWrite,
  input wire logic rxFifoRead,
  input wire logic [4:0] txFifoCount,
  input wire logic txHoldWrite,
  input wire logic overrunError,
  input wire logic parityError,
  input wire logic framingError,
  input wire logic breakIndication,
  input wire logic rclkTick,
  input wire logic autoBaudDone,
  input wire logic autoBaudTimeout,
  output logic irqOut
);
  import uip_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [4:0] trigLevel(input logic [1:0] sel);
    logic [4:0] lvl;
    lvl = `UIP_TRIG_L0;
    case (sel)
      2'h0: lvl = `UIP_TRIG_L0;
      2'h1: lvl = `UIP_TRIG_L1;
      2'h2: lvl = `UIP_TRIG_L2;
      default: lvl = `UIP_TRIG_L3;
    endcase
    return lvl;
  endfunction

  function automatic logic [9:0] wordLen(input logic [1:0] wls);
    return `UIP_WORD_MIN + {8'h00, wls};
  endfunction

  // Negative fill difference is clamped to zero, not wrapped
  function automatic logic [9:0] idleWindow(input logic [1:0] wls, input logic [1:0] trig,
                                            input logic [4:0] held);
    logic [9:0] base;
    logic [9:0] extra;
    logic [4:0] lvl;
    lvl = trigLevel(trig);
    base = (wordLen(wls) * `UIP_IDLE_MUL - `UIP_IDLE_SUB) * `UIP_IDLE_SCALE;
    extra = 10'h000;
    if (held < lvl) begin
      extra = {5'h00, lvl - held} * `UIP_IDLE_SCALE;
    end
    return base + extra + `UIP_IDLE_ADD;
  endfunction

  // Start bit, data bits and parity; the stop bit is left out
  function automatic logic [7:0] charNoStop(input logic [1:0] wls, input logic par);
    logic [7:0] bits;
    bits = 8'h01 + 8'(wordLen(wls)) + {7'h00, par};
    return bits * `UIP_RCLK_PER_BIT;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State and idle timer

  uip_state_t state_reg;
  uip_state_t state_next;
  uip_tmr_if tmr ();

  uip_idle_timer u_timer (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .ce(ce),
    .tmr(tmr.timer)
  );

  assign tmr.tick = rclkTick;
  assign tmr.activity = rxFifoWrite | rxFifoRead;
  assign tmr.armed = (rxFifoCount != 5'h00);
  assign tmr.window = idleWindow(state_reg.lcrWls, state_reg.fcrTrig, rxFifoCount);

  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;
  assign irqOut = state_reg.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic accessWait;
  logic accessDone;
  logic rdDone;
  logic wrDone;
  logic mapped;
  logic iirReadActive;
  logic txEmpty;
  logic [3:0] errNow;
  uip_code_t liveCode;
  logic [31:0] readMux;
  logic [`UIP_ST_W-1:0] events;

  always_comb begin
    state_next = state_reg;
    // One wait state: pready rises on the second access cycle
    accessWait = psel && penable && !state_reg.pready;
    accessDone = psel && penable && state_reg.pready;
    rdDone = accessDone && !pwrite;
    wrDone = accessDone && pwrite;
    iirReadActive = psel && !pwrite && (paddr == `UIP_OFF_IIR);
    txEmpty = (txFifoCount == 5'h00);
    errNow = {breakIndication, framingError, parityError, overrunError};

    mapped = 1'b1;
    readMux = 32'h0000_0000;
    if (paddr == `UIP_OFF_IIR) begin
      readMux[`UIP_IIR_PEND_BIT] = state_reg.iirPendN;
      readMux[`UIP_IIR_CODE_LSB +: 3] = state_reg.iirCode;
      readMux[`UIP_IIR_FIFO_LSB +: 2] = {2{state_reg.fcrEn}};
      readMux[`UIP_IIR_ABEND_BIT] = state_reg.abEnd && state_reg.ien[`UIP_ST_ABEND];
      readMux[`UIP_IIR_ABTO_BIT] = state_reg.abTimeout && state_reg.ien[`UIP_ST_ABTO];
    end else if (paddr == `UIP_OFF_FCR) begin
      readMux[`UIP_FCR_EN_BIT] = state_reg.fcrEn;
      readMux[`UIP_FCR_TRIG_LSB +: 2] = state_reg.fcrTrig;
    end else if (paddr == `UIP_OFF_LCR) begin
      readMux[`UIP_LCR_WLS_LSB +: 2] = state_reg.lcrWls;
      readMux[`UIP_LCR_STOP_BIT] = state_reg.lcrStop;
      readMux[`UIP_LCR_PAR_BIT] = state_reg.lcrParity;
    end else if (paddr == `UIP_OFF_LSR) begin
      readMux[`UIP_LSR_RDR_BIT] = (rxFifoCount != 5'h00);
      readMux[`UIP_LSR_ERR_LSB +: 4] = state_reg.lsrErr;
      readMux[`UIP_LSR_TRANSMIT_EMPTY_IRQ_BIT] = txEmpty;
    end else if (paddr == `UIP_OFF_ABCR) begin
      readMux = 32'h0000_0000;
    end else if (paddr == `UIP_OFF_ISTAT) begin
      readMux[`UIP_ST_W-1:0] = state_reg.status;
    end else if (paddr == `UIP_OFF_IEN) begin
      readMux[`UIP_ST_W-1:0] = state_reg.ien;
    end else if (paddr == `UIP_OFF_ICLR) begin
      readMux = 32'h0000_0000;
    end else begin
      mapped = 1'b0;
    end

    // Bus answer
    state_next.pready = accessWait;
    state_next.pslverr = accessWait && !mapped;
    if (accessWait) begin
      state_next.prdata = readMux;
    end

    // Register writes
    if (wrDone && paddr == `UIP_OFF_FCR) begin
      state_next.fcrEn = pwdata[`UIP_FCR_EN_BIT];
      state_next.fcrTrig = pwdata[`UIP_FCR_TRIG_LSB +: 2];
    end
    if (wrDone && paddr == `UIP_OFF_LCR) begin
      state_next.lcrWls = pwdata[`UIP_LCR_WLS_LSB +: 2];
      state_next.lcrStop = pwdata[`UIP_LCR_STOP_BIT];
      state_next.lcrParity = pwdata[`UIP_LCR_PAR_BIT];
    end
    if (wrDone && paddr == `UIP_OFF_IEN) begin
      state_next.ien = pwdata[`UIP_ST_W-1:0];
    end

    // Line error source; an error in the clearing cycle survives
    if (rdDone && paddr == `UIP_OFF_LSR) begin
      state_next.lsrErr = 4'h0;
      state_next.lineIrq = 1'b0;
    end
    state_next.lsrErr = state_next.lsrErr | errNow;
    if (errNow != 4'h0) begin
      state_next.lineIrq = 1'b1;
    end

    // Receive fill level and idle timeout
    state_next.fillIrq = (rxFifoCount >= trigLevel(state_reg.fcrTrig));
    state_next.idleIrq = tmr.expired;

    // Clears come first, so an empty event in the same cycle wins
    if (txHoldWrite) begin
      state_next.threIrq = 1'b0;
    end
    if (rdDone && paddr == `UIP_OFF_IIR && !state_reg.iirPendN && state_reg.iirCode == `UIP_CODE_TRANSMIT_EMPTY_IRQ) begin
      state_next.threIrq = 1'b0;
    end
    // Transmit empty with start-up postponement
    state_next.txEmptyPrev = txEmpty;
    if (txFifoCount >= 5'h02) begin
      state_next.threHeld2 = 1'b1;
    end
    if (!txEmpty) begin
      state_next.threDelayRun = 1'b0;
    end else if (!state_reg.txEmptyPrev) begin
      if (state_reg.threHeld2) begin
        state_next.threIrq = 1'b1;
        state_next.threHeld2 = 1'b0;
      end else begin
        state_next.threDelay = charNoStop(state_reg.lcrWls, state_reg.lcrParity);
        state_next.threDelayRun = 1'b1;
      end
    end else if (state_reg.threDelayRun && rclkTick) begin
      if (state_reg.threDelay <= 8'h01) begin
        state_next.threDelayRun = 1'b0;
        state_next.threIrq = 1'b1;
      end else begin
        state_next.threDelay = state_reg.threDelay - 8'h01;
      end
    end
    if (state_reg.txEmptyPrev && state_reg.threHeld2 && txEmpty && !state_reg.threIrq) begin
      // Emptied again after a burst without passing through the edge above
      state_next.threIrq = 1'b1;
      state_next.threHeld2 = 1'b0;
    end

    // Auto-baud flags: only the clear bits remove them, set wins
    if (wrDone && paddr == `UIP_OFF_ABCR) begin
      if (pwdata[`UIP_ABCR_END_BIT]) begin
        state_next.abEnd = 1'b0;
      end
      if (pwdata[`UIP_ABCR_TO_BIT]) begin
        state_next.abTimeout = 1'b0;
      end
    end
    if (autoBaudDone) begin
      state_next.abEnd = 1'b1;
    end
    if (autoBaudTimeout) begin
      state_next.abTimeout = 1'b1;
    end

    // Priority encoding; only defined codes can come out
    liveCode = `UIP_CODE_NONE;
    if (state_reg.lineIrq) begin
      liveCode = `UIP_CODE_LINE;
    end else if (state_reg.fillIrq) begin
      liveCode = `UIP_CODE_FILL;
    end else if (state_reg.idleIrq) begin
      liveCode = `UIP_CODE_IDLE;
    end else if (state_reg.threIrq) begin
      liveCode = `UIP_CODE_TRANSMIT_EMPTY_IRQ;
    end
    // Snapshot held from setup through access of an identification read
    if (!iirReadActive) begin
      state_next.iirCode = liveCode;
      state_next.iirPendN = (liveCode == `UIP_CODE_NONE);
    end

    // Sticky status on rising source edges and on the auto-baud input strobes; set wins over clear
    events = '0;
    events[`UIP_ST_LINE] = state_next.lineIrq && !state_reg.lineIrq;
    events[`UIP_ST_FILL] = state_next.fillIrq && !state_reg.fillIrq;
    events[`UIP_ST_IDLE] = state_next.idleIrq && !state_reg.idleIrq;
    events[`UIP_ST_TRANSMIT_EMPTY_IRQ] = state_next.threIrq && !state_reg.threIrq;
    events[`UIP_ST_ABEND] = autoBaudDone;
    events[`UIP_ST_ABTO] = autoBaudTimeout;
    if (wrDone && paddr == `UIP_OFF_ICLR) begin
      state_next.status = state_reg.status & ~pwdata[`UIP_ST_W-1:0];
    end
    state_next.status = state_next.status | events;
    state_next.irq = |(state_next.status & state_next.ien);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_reg <= '0;
      state_reg.iirPendN <= `UIP_RST_IIR_PEND;
      state_reg.iirCode <= `UIP_RST_CODE;
      state_reg.fcrTrig <= `UIP_RST_TRIG;
      state_reg.lcrWls <= `UIP_RST_WLS;
      state_reg.ien <= `UIP_RST_IEN;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

endmodule

`default_nettype wire

// [tb/uip_checker.sv]
// Port-level checker for the interrupt identification block.
// Assumes ce is held high; a low ce freezes timing, so checks pause.
`timescale 1ns/1ps
`default_nettype none

module uip_checker (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irqOut
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b || !ce);
  logic iirRd;
  assign iirRd = psel && penable && pready && !pwrite && paddr == 12'h000 && !pslverr;
  //////////////////////////////////////////////////////////////////
  a_ready_wait: assert property (psel && !penable |=> !pready ##1 pready) else $error("pready not after one wait");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  a_ready_access: assert property (pready |-> psel && penable) else $error("pready outside access");
  a_unmapped_err: assert property (pready && paddr > 12'h01C |-> pslverr && prdata == 32'h0) else $error("unmapped");
  a_mapped_ok: assert property (pready && paddr <= 12'h01C && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped address refused");
  a_wo_zero: assert property (pready && !pwrite && (paddr == 12'h010 || paddr == 12'h01C) |-> prdata == 32'h0)
    else $error("write-only register read nonzero");
  a_nibble_legal: assert property (iirRd |-> prdata[3:0] inside {4'h1, 4'h2, 4'h4, 4'h6, 4'hC})
    else $error("reserved identification value");
  a_pend_code: assert property (iirRd |-> prdata[0] == (prdata[3:1] == 3'h0))
    else $error("pending flag disagrees with code");
  a_mask_irq: assert property (pready && pwrite && paddr == 12'h018 && pwdata[5:0] == 6'h00 |-> ##2 !irqOut[*2])
    else $error("irq high with all sources masked");
  a_rdata_hold: assert property (!pready |-> $stable(prdata)) else $error("read data moved between answers");
  c_line: cover property (iirRd && prdata[3:1] == 3'h3);
  c_idle: cover property (iirRd && prdata[3:1] == 3'h6);
  c_transmit_empty_irq: cover property (iirRd && prdata[3:1] == 3'h1);
  c_irq: cover property ($rose(irqOut));
endmodule

bind uip_ident uip_checker i_chk (.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irqOut(irqOut));

`default_nettype wire

// [tb/uip_far_model.sv]
// Far side: receive and transmit FIFO levels moved by a peer and software, plus the receive clock.
// Takes one operation per opValid cycle from the testbench; all on clk_sys.
`timescale 1ns/1ps
`default_nettype none

module uip_far_model #(
  parameter int TICK_DIV = 2
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic opValid,
  input wire logic [1:0] op,
  output logic [4:0] rxFifoCount,
  output logic rxFifoWrite,
  output logic rxFifoRead,
  output logic [4:0] txFifoCount,
  output logic txHoldWrite,
  output logic rclkTick
);
  int tickCnt;
  always_ff @(posedge clk_sys) begin
    rxFifoWrite <= 1'b0;
    rxFifoRead <= 1'b0;
    txHoldWrite <= 1'b0;
    if (!rst_b) begin
      rxFifoCount <= 5'h00;
      // One character parked so reset gives no empty event
      txFifoCount <= 5'h01;
      tickCnt <= 0;
      rclkTick <= 1'b0;
    end else begin
      tickCnt <= (tickCnt == TICK_DIV - 1) ? 0 : tickCnt + 1;
      rclkTick <= (tickCnt == TICK_DIV - 1);
      if (opValid && op == 2'h0 && rxFifoCount < 5'h10) begin
        rxFifoCount <= rxFifoCount + 5'h01;
        rxFifoWrite <= 1'b1;
      end
      if (opValid && op == 2'h1 && rxFifoCount != 5'h00) begin
        rxFifoCount <= rxFifoCount - 5'h01;
        rxFifoRead <= 1'b1;
      end
      if (opValid && op == 2'h2) begin
        txFifoCount <= txFifoCount + 5'h01;
        txHoldWrite <= 1'b1;
      end
      if (opValid && op == 2'h3 && txFifoCount != 5'h00) begin
        txFifoCount <= txFifoCount - 5'h01;
      end
    end
  end
endmodule

`default_nettype wire

// [tb/tb_uip_interrupt_priority_id.sv]
// Self-checking bench: APB register sequences against the identification block and far-side model.
// Assumes 5-bit words, no parity; the receive tick comes every TICK_DIV cycles.
`timescale 1ns/1ps
`default_nettype none

module tb_uip_interrupt_priority_id;
  localparam int TICK_DIV = 2;
  localparam int LIMIT = 20000;
  logic clk_sys, rst_b, ce, psel, penable, pwrite, pready, pslverr, irqOut, opValid, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [1:0] op, abIn;
  logic [3:0] errIn;
  logic [4:0] rxFifoCount, txFifoCount;
  logic rxFifoWrite, rxFifoRead, txHoldWrite, rclkTick;
  int bad_count, tests_run, cycles, i, win, dly;
  int thr[4] = '{1, 4, 8, 14};

  uip_ident i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxFifoCount(rxFifoCount), .rxFifoWrite(rxFifoWrite), .rxFifoRead(rxFifoRead), .txFifoCount(txFifoCount),
    .txHoldWrite(txHoldWrite), .overrunError(errIn[0]), .parityError(errIn[1]), .framingError(errIn[2]),
    .breakIndication(errIn[3]), .rclkTick(rclkTick), .autoBaudDone(abIn[0]), .autoBaudTimeout(abIn[1]),
    .irqOut(irqOut));
  uip_far_model #(.TICK_DIV(TICK_DIV)) i_far (.clk_sys(clk_sys), .rst_b(rst_b), .opValid(opValid), .op(op),
    .rxFifoCount(rxFifoCount), .rxFifoWrite(rxFifoWrite), .rxFifoRead(rxFifoRead), .txFifoCount(txFifoCount),
    .txHoldWrite(txHoldWrite), .rclkTick(rclkTick));

  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      bad_count++;
      test_done();
    end
  end
  //////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Idle edge first, so a released strobe is never raised in the same step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(what, exp & m, q & m);
  endtask
  task automatic act(input logic [1:0] o, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      opValid <= 1'b1;
      op <= o;
      @(posedge clk_sys);
      opValid <= 1'b0;
    end
    // Timer, source and snapshot each take a cycle before a read may freeze
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic pulse_in(input logic [3:0] err, input logic [1:0] ab);
    @(posedge clk_sys);
    errIn <= err;
    abIn <= ab;
    @(posedge clk_sys);
    errIn <= 4'h0;
    abIn <= 2'h0;
  endtask
  //////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    rst_b = 1'b0;
    ce = 1'b1;
    {psel, penable, pwrite, opValid} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    op = 2'h0;
    errIn = 4'h0;
    abIn = 2'h0;
    {bad_count, tests_run, cycles} = 0;
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd_chk("ident reset", 12'h000, 32'h001, 32'h3FF);
    rd_chk("fifo ctl reset", 12'h004, 32'h0, 32'hFF);
    rd_chk("enable reset", 12'h018, 32'h0, 32'h3F);
    rd_chk("clear reads zero", 12'h01C, 32'h0, 32'hFFFFFFFF);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped pslverr", 32'h1, {31'h0, e});
    $display("test reset done");
    apb(1'b1, 12'h008, 32'h0);
    apb(1'b1, 12'h004, 32'h01);
    act(2'h0, 1);
    for (i = 0; i < 4; i++) begin
      pulse_in(4'h1 << i, 2'h0);
      rd_chk("line code", 12'h000, 32'h6, 32'hF);
      rd_chk("line cause", 12'h00C, 32'h2 << i, 32'h1E);
      rd_chk("fill after line", 12'h000, 32'h4, 32'hF);
    end
    $display("test line errors done");
    for (i = 0; i < 4; i++) begin
      apb(1'b1, 12'h004, 32'h01 | (i << 6));
      act(2'h1, 16);
      act(2'h0, thr[i] - 1);
      rd_chk("below trigger", 12'h000, 32'h1, 32'hF);
      act(2'h0, 1);
      rd_chk("at trigger", 12'h000, 32'h4, 32'hF);
      act(2'h1, 1);
      rd_chk("under trigger", 12'h000, 32'h1, 32'hF);
    end
    $display("test trigger levels done");
    win = ((5 * 7 - 2) * 8 + (4 - 1) * 8 + 1) * TICK_DIV;
    act(2'h1, 16);
    apb(1'b1, 12'h004, 32'h41);
    apb(1'b1, 12'h018, 32'h04);
    act(2'h0, 1);
    repeat (win - 40) @(posedge clk_sys);
    rd_chk("idle early", 12'h000, 32'h1, 32'hF);
    repeat (60) @(posedge clk_sys);
    rd_chk("idle code", 12'h000, 32'hC, 32'hF);
    chk("irq on idle", 32'h1, {31'h0, irqOut});
    apb(1'b1, 12'h01C, 32'h04);
    repeat (2) @(posedge clk_sys);
    chk("irq cleared", 32'h0, {31'h0, irqOut});
    rd_chk("status cleared", 12'h014, 32'h0, 32'h4);
    act(2'h0, 1);
    rd_chk("idle cleared", 12'h000, 32'h1, 32'hF);
    $display("test idle timeout done");
    dly = (1 + 5 + 0) * 16 * TICK_DIV;
    act(2'h1, 16);
    apb(1'b1, 12'h018, 32'h00);
    act(2'h3, 1);
    repeat (dly / 2 - 16) @(posedge clk_sys);
    rd_chk("empty postponed", 12'h000, 32'h1, 32'hF);
    repeat (dly / 2 + 40) @(posedge clk_sys);
    rd_chk("empty code", 12'h000, 32'h2, 32'hF);
    rd_chk("cleared by ident", 12'h000, 32'h1, 32'hF);
    act(2'h2, 2);
    act(2'h3, 2);
    rd_chk("empty at once", 12'h000, 32'h2, 32'hF);
    act(2'h2, 1);
    rd_chk("cleared by write", 12'h000, 32'h1, 32'hF);
    $display("test transmit empty done");
    apb(1'b1, 12'h018, 32'h30);
    for (i = 0; i < 2; i++) begin
      pulse_in(4'h0, 2'h1 << i);
      rd_chk("baud flag", 12'h000, (32'h100 << i) | 32'h1, 32'h30F);
      rd_chk("baud flag kept", 12'h000, (32'h100 << i) | 32'h1, 32'h30F);
      chk("irq on baud", 32'h1, {31'h0, irqOut});
      apb(1'b1, 12'h010, 32'h100 << i);
      rd_chk("baud flag clear", 12'h000, 32'h1, 32'h30F);
    end
    apb(1'b1, 12'h01C, 32'h3F);
    repeat (2) @(posedge clk_sys);
    chk("irq after clear", 32'h0, {31'h0, irqOut});
    $display("test auto-baud done");
    test_done();
  end
endmodule

`default_nettype wire
